// ==== pkg/fapsc_pkg.sv ====
// Purpose: shared constants for the fault alert and pin strap block
// Assumes: AHB-Lite register map, 25 MHz ref_clk
// Notes: strap codes are 4 bit, code 4'hF means the strap is floating
package fapsc_pkg;
    localparam int unsigned CLK_HZ = 25000000;
    localparam logic [3:0] STRAP_OPEN = 4'hF;
    // register byte offsets
    localparam logic [7:0] A_CTRL = 8'h00;
    localparam logic [7:0] A_NV_CFG = 8'h04;
    localparam logic [7:0] A_NV_ADDR = 8'h08;
    localparam logic [7:0] A_NV_SET = 8'h0C;
    localparam logic [7:0] A_PROP = 8'h10;
    localparam logic [7:0] A_RETRY = 8'h14;
    localparam logic [7:0] A_MASK0 = 8'h18;
    localparam logic [7:0] A_MASK1 = 8'h1C;
    localparam logic [7:0] A_STAT0 = 8'h20;
    localparam logic [7:0] A_STAT1 = 8'h24;
    localparam logic [7:0] A_SUMM = 8'h28;
    localparam logic [7:0] A_PADS = 8'h2C;
    localparam logic [7:0] A_CFG_OUT = 8'h30;
    localparam logic [7:0] A_VOUT0 = 8'h34;
    localparam logic [7:0] A_VOUT1 = 8'h38;
    localparam logic [7:0] A_ADDR = 8'h3C;
    // control register bits (bits 7:0 self-clear after one cycle; C_RUN0, C_RUN1, C_EXT_CLK hold their value)
    localparam int C_CLEAR = 0;
    localparam int C_MFR_RST = 1;
    localparam int C_RESTORE = 2;
    localparam int C_ARA = 3;
    localparam int C_BUSY = 4;
    localparam int C_RUN0 = 8;
    localparam int C_RUN1 = 9;
    localparam int C_EXT_CLK = 10;
    // global config word bits
    localparam int G_IGNORE_STRAPS = 6;
    localparam int G_SYNC_OFF = 4;
    // per-channel status bits
    localparam int S_OV = 0;
    localparam int S_UV = 1;
    localparam int S_OC = 2;
    localparam int S_OT = 3;
    localparam int S_EXT = 4;
    localparam int S_PLL = 5;
    localparam int S_VOUT_WARN = 6;
    localparam int S_CML = 7;
    localparam int PAD_SYNC_INT = 10;
    // summary word layout
    localparam int W_BUSY = 7;
    localparam int W_OTHER = 0;
    localparam int W_VOUT = 15;
    localparam int W_IOUT = 14;
    localparam int W_EXT = 13;
    localparam int W_MFR = 12;
    // retry interval, printed limits, 1 ms step
    localparam int unsigned RETRY_MIN_MS = 120;
    localparam int unsigned RETRY_MAX_MS = 83880;
    localparam int unsigned MS_NS = 1000000;
    localparam int unsigned CLK_NS = 1000000000 / CLK_HZ;
    localparam int unsigned MS_CYC = MS_NS / CLK_NS;
    // global address codes and the all-pages code
    localparam logic [6:0] GLOBAL_ALL = 7'h5A;
    localparam logic [6:0] GLOBAL_PAGED = 7'h5B;
    localparam logic [7:0] PAGE_ALL = 8'hFF;
    typedef enum logic [1:0] {
        FAPSC_IDLE, FAPSC_SOFT, FAPSC_ON, FAPSC_WAIT
    } fapsc_ch_t;
endpackage

// ==== rtl/fapsc_top.sv ====
// Purpose: fault alert, fault pins, retry and strap configuration loader
// Assumes: straps arrive as 4-bit codes from an off-block digitiser
// Notes: voltage values are in 1/1000 of a volt code units
`timescale 1ns/100ps
module fapsc_top
    import fapsc_pkg::*;
(
    input wire logic ref_clk,
    input wire logic rstn,
    input wire logic clk_en,
    input wire logic hsel,
    input wire logic [31:0] haddr,
    input wire logic [1:0] htrans,
    input wire logic hwrite,
    input wire logic [2:0] hsize,
    input wire logic [31:0] hwdata,
    input wire logic hready,
    output logic [31:0] hrdata,
    output logic hreadyout,
    output logic hresp,
    input wire logic [3:0] addr_low_selector,
    input wire logic [3:0] addr_high_selector,
    input wire logic [3:0] frequency_strap,
    input wire logic [3:0] out0_voltage_strap,
    input wire logic [3:0] out1_voltage_strap,
    input wire logic [3:0] phase_strap,
    input wire logic [1:0] fault_pin_in,
    input wire logic [7:0] fault_det0,
    input wire logic [7:0] fault_det1,
    input wire logic ext_sync_present,
    input wire logic [6:0] bus_addr,
    input wire logic bus_wr,
    input wire logic [7:0] bus_page,
    output logic [1:0] bus_wr_ch,
    output logic alert_n,
    output logic [1:0] fault_pin_out,
    output logic [1:0] fault_pin_oe,
    output logic sync_out_en,
    output logic [1:0] ch_enable,
    output logic [1:0] soft_start
);
    logic [3:0] s1 [6];
    logic [3:0] s2 [6];
    logic [1:0] fp1, fp2;
    logic sy1, sy2;
    logic [7:0] d1 [2];
    logic [7:0] d2 [2];
    logic ph_a, ph_w;
    logic [7:0] ph_addr;
    logic [31:0] ctrl, nv_cfg, nv_addr, nv_set, prop, retry, mask0, mask1;
    logic [7:0] stat [2];
    logic [7:0] mask [2];
    logic [15:0] vout [2];
    logic [6:0] addr;
    logic [3:0] freq_sel, phase_sel;
    logic busy, mask_ready, sample_req, pads_bit;
    logic [15:0] summ;
    logic [31:0] cfg_out;
    fapsc_ch_t st [2];
    logic [31:0] rcnt [2];
    logic [31:0] retry_cyc;
    logic [16:0] retry_ms;
    logic [1:0] run_q;
    logic acc_wr;

    assign mask[0] = mask0[7:0];
    assign mask[1] = mask1[7:0];

    // two-flop synchronisers on everything that comes from pins
    always_ff @(posedge ref_clk) begin
        if (!rstn) begin
            fp1 <= 2'h3;
            fp2 <= 2'h3;
            sy1 <= 1'b0;
            sy2 <= 1'b0;
        end else if (clk_en) begin
            fp1 <= fault_pin_in;
            fp2 <= fp1;
            sy1 <= ext_sync_present;
            sy2 <= sy1;
        end
    end

    genvar g;
    generate
        for (g = 0; g < 6; g++) begin : g_strap
            // no reset here: straps keep settling through reset so the
            // loader reads real codes on the first edge after release
            always_ff @(posedge ref_clk) begin
                if (clk_en) begin
                    s1[g] <= (g == 0) ? addr_low_selector :
                             (g == 1) ? addr_high_selector :
                             (g == 2) ? frequency_strap :
                             (g == 3) ? out0_voltage_strap :
                             (g == 4) ? out1_voltage_strap : phase_strap;
                    s2[g] <= s1[g];
                end
            end
        end
        for (g = 0; g < 2; g++) begin : g_det
            always_ff @(posedge ref_clk) begin
                if (!rstn) begin
                    d1[g] <= 8'h00;
                    d2[g] <= 8'h00;
                end else if (clk_en) begin
                    d1[g] <= (g == 0) ? fault_det0 : fault_det1;
                    d2[g] <= d1[g];
                end
            end
        end
    endgenerate

    // ahb-lite address phase capture; zero wait states
    always_ff @(posedge ref_clk) begin
        if (!rstn) begin
            ph_a <= 1'b0;
            ph_w <= 1'b0;
            ph_addr <= 8'h00;
        end else if (clk_en && hready) begin
            ph_a <= hsel && htrans[1];
            ph_w <= hwrite;
            ph_addr <= haddr[7:0];
        end
    end
    assign acc_wr = clk_en && ph_a && ph_w;

    // software writable registers; strap sample request stays pending
    // until the sampler has run once after release of reset
    always_ff @(posedge ref_clk) begin
        if (!rstn) begin
            ctrl <= 32'h0000_0000;
            nv_cfg <= 32'h0000_0000;
            nv_addr <= 32'h0000_0040;
            nv_set <= 32'h0000_0000;
            prop <= 32'h0000_0000;
            retry <= 32'h0000_0078;
            mask0 <= 32'h0000_0000;
            mask1 <= 32'h0000_0000;
            mask_ready <= 1'b0;
        end else if (clk_en) begin
            ctrl[7:0] <= 8'h00;
            if (acc_wr) begin
                unique case (ph_addr)
                    A_CTRL: ctrl <= hwdata;
                    A_NV_CFG: nv_cfg <= hwdata;
                    A_NV_ADDR: nv_addr <= hwdata;
                    A_NV_SET: nv_set <= hwdata;
                    A_PROP: prop <= hwdata;
                    A_RETRY: retry <= hwdata;
                    A_MASK0: begin
                        mask0 <= hwdata;
                        mask_ready <= 1'b1;
                    end
                    A_MASK1: begin
                        mask1 <= hwdata;
                        mask_ready <= 1'b1;
                    end
                    default: ;
                endcase
            end
        end
    end

    // strap loader: only at reset release, manufacturer reset or restore
    always_ff @(posedge ref_clk) begin
        if (!rstn) begin
            sample_req <= 1'b1;
            addr <= 7'h00;
            freq_sel <= STRAP_OPEN;
            phase_sel <= STRAP_OPEN;
            vout[0] <= 16'h0000;
            vout[1] <= 16'h0000;
        end else if (clk_en) begin
            if (sample_req || ctrl[C_MFR_RST] || ctrl[C_RESTORE]) begin
                sample_req <= 1'b0;
                // selectors always honored, floating takes stored bits
                addr[6:4] <= (s2[1] == STRAP_OPEN) ? nv_addr[6:4]
                             : s2[1][2:0];
                addr[3:0] <= (s2[0] == STRAP_OPEN) ? nv_addr[3:0]
                             : s2[0];
                if (nv_cfg[G_IGNORE_STRAPS] || s2[2] == STRAP_OPEN)
                    freq_sel <= nv_set[3:0];
                else
                    freq_sel <= s2[2];
                if (nv_cfg[G_IGNORE_STRAPS] || s2[5] == STRAP_OPEN)
                    phase_sel <= nv_set[7:4];
                else
                    phase_sel <= s2[5];
                for (int i = 0; i < 2; i++) begin
                    if (nv_cfg[G_IGNORE_STRAPS] || s2[3+i] == STRAP_OPEN)
                        vout[i] <= nv_set[16*i+15 -: 16];
                    else
                        vout[i] <= {s2[3+i], 8'h00} + 16'h0100;
                end
            end else if (acc_wr && ph_addr == A_VOUT0) begin
                vout[0] <= hwdata[15:0];
            end else if (acc_wr && ph_addr == A_VOUT1) begin
                vout[1] <= hwdata[15:0];
            end
        end
    end

    // limit derivation; percent scaling by multiply and divide by 1000
    function automatic logic [15:0] pct(input logic [15:0] v,
                                        input int num);
        logic [31:0] p;
        p = 32'(v) * 32'(num) / 32'd1000;
        return p[15:0];
    endfunction
    logic [15:0] ov_lim [2];
    logic [15:0] uvw_lim [2];
    generate
        for (g = 0; g < 2; g++) begin : g_lim
            assign ov_lim[g] = pct(vout[g], 1100);
            assign uvw_lim[g] = pct(vout[g], 935);
        end
    endgenerate
    assign cfg_out = {ov_lim[0], uvw_lim[0]};

    // sync pin and pad status; clock-lock when nothing to run from
    always_ff @(posedge ref_clk) begin
        if (!rstn) begin
            sync_out_en <= 1'b0;
            pads_bit <= 1'b0;
        end else if (clk_en) begin
            sync_out_en <= !ctrl[C_EXT_CLK] && !nv_cfg[G_SYNC_OFF]
                           && !sy2;
            pads_bit <= !ctrl[C_EXT_CLK] && !nv_cfg[G_SYNC_OFF];
        end
    end

    // sticky status: set wins over every clear source
    generate
        for (g = 0; g < 2; g++) begin : g_stat
            logic [7:0] ev, clr;
            always_comb begin
                ev = d2[g];
                ev[S_EXT] = d2[g][S_EXT] || !fp2[g];
                // wait for the loader, freq_sel is open until it has run
                ev[S_PLL] = (freq_sel == STRAP_OPEN) && !sy2
                            && !sample_req;
                clr = 8'h00;
                if (ctrl[C_CLEAR] || ctrl[C_MFR_RST] || ctrl[C_ARA] ||
                    (ctrl[C_RUN0+g] && !run_q[g]))
                    clr = 8'hFF;
                if (acc_wr && ph_addr == (g ? A_STAT1 : A_STAT0))
                    clr = clr | hwdata[7:0];
            end
            always_ff @(posedge ref_clk) begin
                if (!rstn) stat[g] <= 8'h00;
                else if (clk_en) stat[g] <= (stat[g] & ~clr) | ev;
            end
        end
    endgenerate

    always_ff @(posedge ref_clk) begin
        if (!rstn) begin
            busy <= 1'b0;
            run_q <= 2'h0;
        end else if (clk_en) begin
            run_q <= ctrl[C_RUN1:C_RUN0];
            if (ctrl[C_BUSY] && ctrl[C_RUN1:C_RUN0] != 2'h0)
                busy <= 1'b1;
            else if (ctrl[C_CLEAR] || ctrl[C_MFR_RST])
                busy <= 1'b0;
        end
    end

    // summary word: masks promote like the bits; pads excluded
    logic [7:0] um [2];
    assign um[0] = stat[0] & (mask_ready ? ~mask[0] : 8'hFF);
    assign um[1] = stat[1] & (mask_ready ? ~mask[1] : 8'hFF);
    always_comb begin
        summ = 16'h0000;
        summ[W_VOUT] = |(um[0][1:0]) | |(um[1][1:0]);
        summ[W_IOUT] = um[0][S_OC] | um[1][S_OC];
        summ[W_EXT] = um[0][S_EXT] | um[1][S_EXT];
        summ[W_MFR] = um[0][S_PLL] | um[1][S_PLL];
        summ[2] = um[0][S_OT] | um[1][S_OT];
        summ[1] = um[0][S_CML] | um[1][S_CML] | um[0][S_VOUT_WARN];
        summ[W_BUSY] = busy;
        summ[W_OTHER] = |summ[15:12];
    end

    // alert pin from a flop, evaluated every cycle with clk_en high
    always_ff @(posedge ref_clk) begin
        if (!rstn) alert_n <= 1'b1;
        else if (clk_en) alert_n <= !(|um[0] || |um[1] || busy);
    end

    // fault pins: open-drain, driven low only for propagated faults
    always_ff @(posedge ref_clk) begin
        if (!rstn) begin
            fault_pin_out <= 2'h0;
            fault_pin_oe <= 2'h0;
        end else if (clk_en) begin
            fault_pin_out <= 2'h0;
            fault_pin_oe[0] <= |(d2[0] & prop[7:0]);
            fault_pin_oe[1] <= |(d2[1] & prop[15:8]);
        end
    end

    // retry interval clamped to the legal range
    always_comb begin
        retry_ms = retry[16:0];
        if (retry[31:0] < 32'(RETRY_MIN_MS)) retry_ms = 17'(RETRY_MIN_MS);
        if (retry[31:0] > 32'(RETRY_MAX_MS)) retry_ms = 17'(RETRY_MAX_MS);
    end
    assign retry_cyc = 32'(retry_ms) * 32'(MS_CYC);

    // per-channel hiccup sequencer: never latches, keeps retrying
    generate
        for (g = 0; g < 2; g++) begin : g_seq
            always_ff @(posedge ref_clk) begin
                if (!rstn) begin
                    st[g] <= FAPSC_IDLE;
                    rcnt[g] <= 32'h0;
                    ch_enable[g] <= 1'b0;
                    soft_start[g] <= 1'b0;
                end else if (clk_en) begin
                    soft_start[g] <= 1'b0;
                    unique case (st[g])
                        FAPSC_IDLE: if (ctrl[C_RUN0+g] && vout[g] != 16'h0)
                            begin
                            st[g] <= FAPSC_SOFT;
                        end
                        FAPSC_SOFT: begin
                            soft_start[g] <= 1'b1;
                            ch_enable[g] <= 1'b1;
                            st[g] <= FAPSC_ON;
                        end
                        FAPSC_ON: if (!ctrl[C_RUN0+g]) begin
                            ch_enable[g] <= 1'b0;
                            st[g] <= FAPSC_IDLE;
                        end else if (|d2[g] || !fp2[g]) begin
                            ch_enable[g] <= 1'b0;
                            rcnt[g] <= 32'h0;
                            st[g] <= FAPSC_WAIT;
                        end
                        FAPSC_WAIT: if (!ctrl[C_RUN0+g]) begin
                            st[g] <= FAPSC_IDLE;
                        end else if (|d2[g]) begin
                            rcnt[g] <= 32'h0;
                        end else if (rcnt[g] >= retry_cyc - 32'h1) begin
                            st[g] <= FAPSC_SOFT;
                        end else begin
                            rcnt[g] <= rcnt[g] + 32'h1;
                        end
                    endcase
                end
            end
        end
    endgenerate

    // global address routing for bus writes
    always_ff @(posedge ref_clk) begin
        if (!rstn) bus_wr_ch <= 2'h0;
        else if (clk_en) begin
            bus_wr_ch <= 2'h0;
            if (bus_wr) begin
                if (bus_addr == GLOBAL_ALL)
                    bus_wr_ch <= 2'h3;
                else if (bus_addr == GLOBAL_PAGED || bus_addr == addr)
                    bus_wr_ch <= (bus_page == PAGE_ALL) ? 2'h3 :
                                 (bus_page[0] ? 2'h2 : 2'h1);
            end
        end
    end

    // read mux, registered for flop outputs; zero on unmapped
    always_ff @(posedge ref_clk) begin
        if (!rstn) hrdata <= 32'h0;
        else if (clk_en && hready) begin
            unique case (haddr[7:0])
                A_CTRL: hrdata <= ctrl;
                A_NV_CFG: hrdata <= nv_cfg;
                A_NV_ADDR: hrdata <= nv_addr;
                A_NV_SET: hrdata <= nv_set;
                A_PROP: hrdata <= prop;
                A_RETRY: hrdata <= retry;
                A_MASK0: hrdata <= mask0;
                A_MASK1: hrdata <= mask1;
                A_STAT0: hrdata <= {24'h0, stat[0]};
                A_STAT1: hrdata <= {24'h0, stat[1]};
                A_SUMM: hrdata <= {16'h0, summ};
                A_PADS: hrdata <= {21'h0, pads_bit, 10'h0};
                A_CFG_OUT: hrdata <= cfg_out;
                A_VOUT0: hrdata <= {16'h0, vout[0]};
                A_VOUT1: hrdata <= {16'h0, vout[1]};
                A_ADDR: hrdata <= {21'h0, phase_sel, freq_sel, 3'h0};
                default: hrdata <= 32'h0;
            endcase
        end
    end

    always_ff @(posedge ref_clk) begin
        if (!rstn) begin
            hreadyout <= 1'b1;
            hresp <= 1'b0;
        end else begin
            hreadyout <= 1'b1;
            hresp <= 1'b0;
        end
    end
endmodule

// ==== testbench/fapsc_properties.sv ====
// Purpose: port checker for fapsc_top
// Assumes: one clock domain, synchronous active-low reset
// Notes: frozen state while clk_en is low is checked too
`timescale 1ns/100ps
module fapsc_props
    import fapsc_pkg::*;
(
    input wire logic ref_clk,
    input wire logic rstn,
    input wire logic clk_en,
    input wire logic hreadyout,
    input wire logic hresp,
    input wire logic [6:0] bus_addr,
    input wire logic bus_wr,
    input wire logic [7:0] bus_page,
    input wire logic [1:0] bus_wr_ch,
    input wire logic alert_n,
    input wire logic [1:0] fault_pin_out,
    input wire logic [1:0] fault_pin_oe,
    input wire logic [1:0] soft_start
);
    default clocking @(posedge ref_clk); endclocking
    default disable iff (!rstn);
    // zero wait states, never an error response
    bus_okay_a: assert property (hreadyout && !hresp)
        else $error("bus slave stalled or erred");
    // global address hits both channels one cycle later
    global_all_a: assert property (bus_wr && clk_en && bus_addr == GLOBAL_ALL |=> bus_wr_ch == 2'h3)
        else $error("global write missed a channel");
    paged_zero_a: assert property (bus_wr && clk_en && bus_addr == GLOBAL_PAGED && bus_page == 8'h00 |=> bus_wr_ch == 2'h1)
        else $error("paged global page 0 wrong");
    paged_one_a: assert property (bus_wr && clk_en && bus_addr == GLOBAL_PAGED && bus_page == 8'h01 |=> bus_wr_ch == 2'h2)
        else $error("paged global page 1 wrong");
    quiet_bus_a: assert property (!bus_wr && clk_en |=> bus_wr_ch == 2'h0)
        else $error("channel write without bus write");
    // a stalled clock enable must hold alert_n and fault_pin_oe
    frozen_state_a: assert property (!clk_en |=> $stable(alert_n) && $stable(fault_pin_oe))
        else $error("state moved while frozen");
    // fault pins are open drain: only the enable may change
    pin_release_a: assert property (fault_pin_out == 2'h0)
        else $error("fault pin driven high");
    start_pulse_a: assert property (soft_start[0] && clk_en |=> !soft_start[0])
        else $error("soft start longer than a pulse");
endmodule

bind fapsc_top fapsc_props u_props (.ref_clk, .rstn, .clk_en, .hreadyout,
    .hresp, .bus_addr, .bus_wr, .bus_page, .bus_wr_ch, .alert_n,
    .fault_pin_out, .fault_pin_oe, .soft_start);

// ==== testbench/fapsc_peer.sv ====
// Purpose: peer controller sharing the two fault lines
// Assumes: lines are open drain with pull-ups
// Notes: peer_pull high makes the peer hold that line low
`timescale 1ns/100ps
module fapsc_peer (
    input wire logic [1:0] fault_pin_oe,
    input wire logic [1:0] fault_pin_out,
    input wire logic [1:0] peer_pull,
    output logic [1:0] fault_pin_in
);
    // wired-and of both parties, pull-up when nobody drives
    always_comb begin
        for (int i = 0; i < 2; i++) begin
            fault_pin_in[i] = (fault_pin_oe[i] ? fault_pin_out[i] : 1'b1)
                & !peer_pull[i];
        end
    end
endmodule

// ==== testbench/testbench.sv ====
// Purpose: self-checking bench for fapsc_top
// Assumes: zero wait-state slave, two-flop input synchronisers
// Notes: retry timing is not run, its minimum is 3M cycles
`timescale 1ns/100ps
module testbench
    import fapsc_pkg::*;
;
    logic ref_clk = 0, rstn = 0, clk_en = 1, hsel = 0, hwrite = 0;
    logic bus_wr = 0, ext_sync_present = 0, hreadyout, hresp, alert_n;
    logic sync_out_en;
    logic [31:0] haddr = '0, hwdata = '0, hrdata, rd;
    logic [1:0] htrans = '0, peer_pull = '0, fault_pin_in, fault_pin_out;
    logic [1:0] fault_pin_oe, bus_wr_ch, ch_enable, soft_start;
    logic [2:0] hsize = 3'h2;
    logic [7:0] fault_det0 = '0, fault_det1 = '0, bus_page = '0, p;
    logic [6:0] bus_addr = '0, a;
    logic [3:0] addr_low_selector = 4'h5, addr_high_selector = 4'h2;
    logic [3:0] frequency_strap = 4'h2, phase_strap = 4'h0;
    logic [3:0] out0_voltage_strap = 4'h3, out1_voltage_strap = 4'hF;
    logic [15:0] seed = 16'h07AA;
    int n_fail = 0, compares = 0, cyc = 0;

    fapsc_top DUT (.ref_clk, .rstn, .clk_en, .hsel, .haddr, .htrans,
        .hwrite, .hsize, .hwdata, .hready(hreadyout), .hrdata, .hreadyout,
        .hresp, .addr_low_selector, .addr_high_selector, .frequency_strap,
        .out0_voltage_strap, .out1_voltage_strap, .phase_strap,
        .fault_pin_in, .fault_det0, .fault_det1, .ext_sync_present,
        .bus_addr, .bus_wr, .bus_page, .bus_wr_ch, .alert_n, .fault_pin_out,
        .fault_pin_oe, .sync_out_en, .ch_enable, .soft_start);
    fapsc_peer peer (.fault_pin_oe, .fault_pin_out, .peer_pull,
        .fault_pin_in);

    initial begin
        forever #20 ref_clk = ~ref_clk;
    end
    // hang guard, the sequence needs well under 2000 cycles
    always @(posedge ref_clk) begin
        cyc <= cyc + 1;
        if (cyc == 20000) begin
            n_fail++;
            wrap_up;
        end
    end

    function automatic logic [15:0] lfsr(input logic [15:0] s);
        return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
    endfunction
    // page 0xFF or the all-channel address reach both channels
    function automatic logic [1:0] exp_ch(input logic [6:0] ad,
                                          input logic [7:0] pg);
        if (ad == GLOBAL_ALL || pg == PAGE_ALL) return 2'h3;
        return (pg == 8'h00) ? 2'h1 : 2'h2;
    endfunction
    // device address: high selector gives the top 3 bits
    function automatic logic [6:0] dev_addr(input logic [3:0] hi,
                                            input logic [3:0] lo);
        return {hi[2:0], lo};
    endfunction
    // strap code c means (c + 1) * 256; ov +10 percent, uv warn -6.5
    function automatic logic [31:0] exp_lim(input logic [3:0] code);
        int v;
        v = (code + 1) * 256;
        return {16'(v * 110 / 100), 16'(v * 935 / 1000)};
    endfunction

    task automatic chk(input logic [31:0] got, input logic [31:0] exp,
                       input string what);
        compares++;
        if (got !== exp) begin
            n_fail++;
            $display("[FAIL] %0t %s", $time, what);
        end
    endtask
    // one single AHB-Lite transfer, entered just after a rising edge
    task automatic ahb(input logic w, input logic [7:0] ad,
                       input logic [31:0] d);
        hsel <= 1'b1;
        htrans <= 2'h2;
        haddr <= {24'h0, ad};
        hwrite <= w;
        @(posedge ref_clk);
        while (hreadyout !== 1'b1) @(posedge ref_clk);
        htrans <= 2'h0;
        hwdata <= d;
        @(posedge ref_clk);
        while (hreadyout !== 1'b1) @(posedge ref_clk);
        rd = hrdata;
    endtask
    task automatic rdchk(input logic [7:0] ad, input logic [31:0] exp,
                         input string what);
        ahb(1'b0, ad, 32'h0);
        chk(rd, exp, what);
    endtask
    // bounded poll, alert_n follows a two-flop input synchroniser first
    task automatic wait_alert(input logic v, input string what);
        for (int i = 0; i < 10 && alert_n !== v; i++) @(posedge ref_clk);
        chk({31'h0, alert_n}, {31'h0, v}, what);
    endtask
    task automatic wrap_up;
        $display("compares %0d mismatches %0d", compares, n_fail);
        if (n_fail == 0 && compares > 0) $display("== PASSED ==");
        else $display("== FAILED ==");
        $finish;
    endtask

    initial begin
        repeat (20) @(posedge ref_clk);
        rstn <= 1'b1;
        repeat (4) @(posedge ref_clk);
        rdchk(A_NV_ADDR, 32'h40, "stored address reset");
        rdchk(A_RETRY, 32'h78, "retry reset");
        ahb(1'b1, A_RETRY, 32'h5);
        // the clamp acts on the interval, the register keeps the write
        rdchk(A_RETRY, 32'h5, "retry stored low");
        ahb(1'b1, A_RETRY, 32'h186A0);
        rdchk(A_RETRY, 32'h186A0, "retry stored high");
        rdchk(8'h40, 32'h0, "unmapped read");
        p = {phase_strap, frequency_strap};
        rdchk(A_ADDR, {21'h0, p, 3'h0}, "strap frequency");
        rdchk(A_CFG_OUT, exp_lim(out0_voltage_strap), "limits");
        rdchk(A_PADS, 32'h400, "internal sync pad");
        // poll the control word before issuing commands
        rdchk(A_CTRL, 32'h0, "control idle");
        ahb(1'b1, A_CTRL, 32'h400);
        // pad bit settles one cycle after the control write
        @(posedge ref_clk);
        rdchk(A_PADS, 32'h0, "external clock pad");
        chk({31'h0, sync_out_en}, 32'h0, "sync out off");
        ahb(1'b1, A_CTRL, 32'h0);
        $display("registers and sync done");
        fault_det0 <= 8'h08;
        wait_alert(1'b0, "over temperature alert");
        fault_det0 <= 8'h00;
        repeat (4) @(posedge ref_clk);
        chk({31'h0, alert_n}, 32'h0, "alert held");
        rdchk(A_STAT0, 32'h08, "status bit");
        ahb(1'b1, A_STAT0, 32'h08);
        wait_alert(1'b1, "write one release");
        fault_det1 <= 8'h01;
        wait_alert(1'b0, "overvoltage alert");
        rdchk(A_SUMM, 32'h8001, "summary other bit");
        fault_det1 <= 8'h00;
        ahb(1'b1, A_CTRL, 32'h1);
        wait_alert(1'b1, "clear faults release");
        ahb(1'b1, A_PROP, 32'h01);
        fault_det0 <= 8'h01;
        wait_alert(1'b0, "propagated fault alert");
        chk({30'h0, fault_pin_oe}, 32'h1, "fault pin pulled");
        fault_det0 <= 8'h00;
        ahb(1'b1, A_PROP, 32'h0);
        // own pulled pin also reads back as external; let it drain first
        repeat (4) @(posedge ref_clk);
        ahb(1'b1, A_CTRL, 32'h1);
        wait_alert(1'b1, "propagated fault cleared");
        peer_pull <= 2'h2;
        wait_alert(1'b0, "external fault alert");
        peer_pull <= 2'h0;
        rdchk(A_STAT1, 32'h10, "external fault status");
        ahb(1'b1, A_STAT1, 32'h10);
        wait_alert(1'b1, "external fault cleared");
        $display("alert and fault pins done");
        ahb(1'b1, A_MASK0, 32'hFF);
        ahb(1'b1, A_MASK1, 32'hFF);
        fault_det0 <= 8'h20;
        clk_en <= 1'b0;
        repeat (3) @(posedge ref_clk);
        clk_en <= 1'b1;
        repeat (8) @(posedge ref_clk);
        chk({31'h0, alert_n}, 32'h1, "masked fault quiet");
        fault_det0 <= 8'h00;
        ahb(1'b1, A_STAT0, 32'h20);
        ahb(1'b1, A_CTRL, 32'h100);
        ahb(1'b1, A_CTRL, 32'h110);
        wait_alert(1'b0, "busy unmaskable");
        rdchk(A_SUMM, 32'h80, "busy summary");
        ahb(1'b1, A_CTRL, 32'h1);
        wait_alert(1'b1, "busy cleared");
        $display("masks and busy done");
        // only global addresses are sent, never assigned to a part
        for (int i = 0; i < 24; i++) begin
            seed = lfsr(seed);
            a = seed[0] ? GLOBAL_ALL : GLOBAL_PAGED;
            p = (seed[2:1] == 2'h0) ? PAGE_ALL : {7'h0, seed[1]};
            bus_addr <= a;
            bus_page <= p;
            bus_wr <= 1'b1;
            @(posedge ref_clk);
            bus_wr <= 1'b0;
            @(posedge ref_clk);
            chk({30'h0, bus_wr_ch}, {30'h0, exp_ch(a, p)}, "global");
        end
        // own address from the straps, paged to channel 1
        bus_addr <= dev_addr(addr_high_selector, addr_low_selector);
        bus_page <= 8'h01;
        bus_wr <= 1'b1;
        @(posedge ref_clk);
        bus_wr <= 1'b0;
        @(posedge ref_clk);
        chk({30'h0, bus_wr_ch}, 32'h2, "device address");
        $display("global writes done");
        wrap_up;
    end
endmodule
